// *** design/sdram_ctrl_config_and_init.sv ***
// Behaviour
// - reset returns all registers to defaults
// - launch bit starts self-run init sequence
// - registers decoded at fixed base, offsets
// - overlap bit allows commands during auto-precharge
// - reorder only when enabled; sub-option bits
// - exchange swaps higher-priority arrivals; port option
// - boundary select; manual refresh pulse issues
// - close-page bit forces auto-precharge
// - periodic refresh only while enabled
// - early write waits for all data
// - dll lock shown in read-only bit
// - clock stop: precharge, cke low, hold
// - turnaround clock between chip selects
// - dll guard blocks commands during settling
// - four burst interruption enables
// - self-refresh request; power-up via exit
// - termination off at zero, else on
// - ecc mode four-way select
// - mode push sends extended then normal
// - half width data channel select
`timescale 1ns/1ps
module sdram_ctrl_config_and_init #(
  parameter logic [63:0] BASE_ADDR = sdram_cfg_pkg::CFG_BASE,
  parameter int PWRUP_WAIT = sdram_cfg_pkg::PWRUP_CYC,
  parameter int REFI = sdram_cfg_pkg::REFI_CYC,
  parameter int DLL_WAIT = sdram_cfg_pkg::DLL_CYC,
  parameter int INIT_REFS = sdram_cfg_pkg::INIT_REF_CNT
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [63:0] cfg_addr,
  input wire logic [63:0] cfg_wdata,
  output logic [63:0] cfg_rdata,
  output logic cfg_rd_valid,
  input wire logic dll_lock_in,
  input wire logic burst_boundary,
  input wire logic cmd_boundary,
  output logic [2:0] mem_cmd,
  output logic mem_cke,
  output logic mem_ready,
  output logic cmd_hold,
  output logic overlap_precharge_cmd,
  output logic reorder_enable,
  output logic reorder_priority,
  output logic reorder_bank_split,
  output logic conflict_check_enable,
  output logic reorder_rw_same,
  output logic preempt_exchange,
  output logic swap_same_port,
  output logic close_page_policy,
  output logic early_write_issue,
  output logic bank_count_select,
  output logic cs_turnaround_enable,
  output logic write_preempt_write,
  output logic read_preempt_read,
  output logic preempt_autoprecharge,
  output logic read_breaks_write_burst,
  output logic odt_enable,
  output logic [1:0] termination_select,
  output logic ecc_check_en,
  output logic ecc_correct_en,
  output logic ecc_dev_absent,
  output logic half_width_data
);

  // ------------------------------------------------------------
  // register decode
  // ------------------------------------------------------------
  function automatic logic [63:0] wmask(input logic [3:0] idx);
    case (idx)
      4'h0: wmask = sdram_cfg_pkg::WMASK_0;
      4'h1: wmask = sdram_cfg_pkg::WMASK_1;
      4'h2: wmask = sdram_cfg_pkg::WMASK_2;
      4'h3: wmask = sdram_cfg_pkg::WMASK_3;
      4'h4: wmask = sdram_cfg_pkg::WMASK_4;
      4'h5: wmask = sdram_cfg_pkg::WMASK_5;
      default: wmask = 64'h0000_0000_0000_0000;
    endcase
  endfunction

  logic [63:0] cfg_ff [sdram_cfg_pkg::NUM_REGS];
  logic [63:0] cfg_rdata_ff;
  logic cfg_rd_valid_ff;
  logic dll_locked_ff;

  wire base_hit = (cfg_addr[63:8] == BASE_ADDR[63:8]) && (cfg_addr[3:0] == 4'h0);
  wire [3:0] reg_idx = cfg_addr[7:4];
  wire idx_ok = (reg_idx < 4'(sdram_cfg_pkg::NUM_REGS));
  wire wr_hit = cfg_wr && base_hit && idx_ok;
  wire rd_hit = cfg_rd && base_hit && idx_ok;
  wire wr_reg0 = wr_hit && ({reg_idx, 4'h0} == sdram_cfg_pkg::OFS_PAGE_REFRESH);
  wire wr_reg3 = wr_hit && ({reg_idx, 4'h0} == sdram_cfg_pkg::OFS_INIT_SWAP);
  wire wr_reg4 = wr_hit && ({reg_idx, 4'h0} == sdram_cfg_pkg::OFS_ECC_TERM);

  wire manual_ref_pulse = wr_reg0 && cfg_wdata[sdram_cfg_pkg::B_MANUAL_REF];
  wire mode_push_pulse = wr_reg4 && cfg_wdata[sdram_cfg_pkg::B_MODE_PUSH];
  // launch seen on the write that sets it
  wire launch_pulse = wr_reg3 && cfg_wdata[sdram_cfg_pkg::B_LAUNCH];

  genvar gi;
  generate
    for (gi = 0; gi < sdram_cfg_pkg::NUM_REGS; gi++) begin : g_reg
      always_ff @(posedge mclk) begin
        if (sys_rst) begin
          cfg_ff[gi] <= sdram_cfg_pkg::RST_VALUE;
        end else if (wr_hit && (reg_idx == 4'(gi))) begin
          cfg_ff[gi] <= cfg_wdata & wmask(4'(gi));
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // read path
  // ------------------------------------------------------------
  // lock status merged into its read-only bit
  wire [63:0] lock_word = {63'h0, dll_locked_ff} << sdram_cfg_pkg::B_DLL_LOCK;
  wire [63:0] rd_word = cfg_ff[reg_idx[2:0]] |
                        (({reg_idx, 4'h0} == sdram_cfg_pkg::OFS_WRITE_DLL) ? lock_word : 64'h0);

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cfg_rdata_ff <= 64'h0000_0000_0000_0000;
      cfg_rd_valid_ff <= 1'b0;
      dll_locked_ff <= 1'b0;
    end else begin
      // unmapped reads answer zero
      cfg_rdata_ff <= rd_hit ? rd_word : 64'h0000_0000_0000_0000;
      cfg_rd_valid_ff <= cfg_rd;
      dll_locked_ff <= dll_lock_in;
    end
  end

  // ------------------------------------------------------------
  // field taps
  // ------------------------------------------------------------
  wire [63:0] r0 = cfg_ff[0];
  wire [63:0] r1 = cfg_ff[1];
  wire [63:0] r2 = cfg_ff[2];
  wire [63:0] r3 = cfg_ff[3];
  wire [63:0] r4 = cfg_ff[4];
  wire reorder_on = r2[sdram_cfg_pkg::B_REORDER];
  wire exch_on = reorder_on && r3[sdram_cfg_pkg::B_EXCHANGE];
  wire [1:0] term_f = r4[sdram_cfg_pkg::B_TERM_LO +: 2];
  wire [1:0] ecc_f = r4[sdram_cfg_pkg::B_ECC_LO +: 2];
  wire clock_stop_req = r2[sdram_cfg_pkg::B_CLOCK_STOP];
  wire self_ref_req = r3[sdram_cfg_pkg::B_SELF_REF];
  wire dll_guard = r2[sdram_cfg_pkg::B_DLL_GUARD];
  wire ref_by_cmd = r0[sdram_cfg_pkg::B_REF_BOUNDARY];
  wire periodic_on = r4[sdram_cfg_pkg::B_PERIODIC];

  // ------------------------------------------------------------
  // policy outputs
  // ------------------------------------------------------------
  logic [24:0] pol_ff;
  wire [24:0] nxt_pol = {
    r0[sdram_cfg_pkg::B_OVERLAP],
    reorder_on,
    reorder_on && r2[sdram_cfg_pkg::B_PRIORITY],
    reorder_on && r0[sdram_cfg_pkg::B_BANK_SPLIT],
    reorder_on && r0[sdram_cfg_pkg::B_CONFLICT],
    reorder_on && r3[sdram_cfg_pkg::B_RW_SAME],
    exch_on,
    exch_on && r3[sdram_cfg_pkg::B_SWAP_PORT],
    r0[sdram_cfg_pkg::B_CLOSE_PAGE],
    r1[sdram_cfg_pkg::B_EARLY_WRITE],
    r1[sdram_cfg_pkg::B_BANK_COUNT],
    r2[sdram_cfg_pkg::B_CS_TURN],
    r2[sdram_cfg_pkg::B_WR_PRE_WR],
    r2[sdram_cfg_pkg::B_RD_PRE_RD],
    r2[sdram_cfg_pkg::B_PRE_AP],
    r4[sdram_cfg_pkg::B_RD_BRK_WR],
    term_f != sdram_cfg_pkg::TERM_OFF,
    term_f,
    (ecc_f == sdram_cfg_pkg::ECC_REPORT) || (ecc_f == sdram_cfg_pkg::ECC_CORRECT),
    ecc_f == sdram_cfg_pkg::ECC_CORRECT,
    ecc_f == sdram_cfg_pkg::ECC_ABSENT,
    r3[sdram_cfg_pkg::B_HALF_WIDTH],
    2'b00
  };

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pol_ff <= 25'h0;
    end else begin
      pol_ff <= nxt_pol;
    end
  end

  assign overlap_precharge_cmd = pol_ff[24];
  assign reorder_enable = pol_ff[23];
  assign reorder_priority = pol_ff[22];
  assign reorder_bank_split = pol_ff[21];
  assign conflict_check_enable = pol_ff[20];
  assign reorder_rw_same = pol_ff[19];
  assign preempt_exchange = pol_ff[18];
  assign swap_same_port = pol_ff[17];
  assign close_page_policy = pol_ff[16];
  assign early_write_issue = pol_ff[15];
  assign bank_count_select = pol_ff[14];
  assign cs_turnaround_enable = pol_ff[13];
  assign write_preempt_write = pol_ff[12];
  assign read_preempt_read = pol_ff[11];
  assign preempt_autoprecharge = pol_ff[10];
  assign read_breaks_write_burst = pol_ff[9];
  assign odt_enable = pol_ff[8];
  assign termination_select = pol_ff[7:6];
  assign ecc_check_en = pol_ff[5];
  assign ecc_correct_en = pol_ff[4];
  assign ecc_dev_absent = pol_ff[3];
  assign half_width_data = pol_ff[2];

  // ------------------------------------------------------------
  // init sequencer
  // ------------------------------------------------------------
  logic [2:0] seq_cmd;
  logic seq_cke, seq_busy, seq_dll, seq_done;

  sdram_init_seq #(
    .WAIT_CYC(PWRUP_WAIT),
    .DLL_WAIT(DLL_WAIT),
    .REF_CNT(INIT_REFS)
  ) u_seq (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .start(launch_pulse),
    .via_sr_exit(r3[sdram_cfg_pkg::B_PWRUP_SR]),
    .seq_cmd(seq_cmd),
    .cke_on(seq_cke),
    .busy(seq_busy),
    .dll_window(seq_dll),
    .done(seq_done)
  );

  // ------------------------------------------------------------
  // refresh request
  // ------------------------------------------------------------
  logic [31:0] refi_cnt_ff;
  logic ref_pend_ff;
  logic mode_pend_ff;
  logic mrs_next_ff;

  wire refi_tick = periodic_on && mem_ready && (refi_cnt_ff == 32'(REFI - 1));
  wire at_boundary = ref_by_cmd ? cmd_boundary : burst_boundary;

  // ------------------------------------------------------------
  // power state
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    P_ACTIVE = 4'h1,
    P_SR_ENTER = 4'h2,
    P_SELFREF = 4'h4,
    P_STOP = 4'h8
  } pwr_state_t;

  pwr_state_t pstate_ff, nxt_pstate;
  logic [2:0] nxt_cmd;
  logic ref_taken, mode_taken;

  // guard widens the blackout over dll settling
  wire may_issue = seq_done || (seq_dll && !dll_guard);

  always_comb begin
    nxt_pstate = pstate_ff;
    nxt_cmd = sdram_cfg_pkg::CMD_NOP;
    ref_taken = 1'b0;
    mode_taken = 1'b0;
    if (seq_cmd != sdram_cfg_pkg::CMD_NOP) begin
      nxt_cmd = seq_cmd;
    end else if (mrs_next_ff) begin
      nxt_cmd = sdram_cfg_pkg::CMD_MRS;
    end else if (may_issue) begin
      case (pstate_ff)
        P_ACTIVE: begin
          if (seq_done && (self_ref_req || clock_stop_req)) begin
            nxt_cmd = sdram_cfg_pkg::CMD_PRE_ALL;
            nxt_pstate = self_ref_req ? P_SR_ENTER : P_STOP;
          end else if (mode_pend_ff) begin
            nxt_cmd = sdram_cfg_pkg::CMD_EMRS;
            mode_taken = 1'b1;
          end else if (ref_pend_ff && at_boundary) begin
            nxt_cmd = sdram_cfg_pkg::CMD_REFRESH;
            ref_taken = 1'b1;
          end
        end
        P_SR_ENTER: begin
          nxt_cmd = sdram_cfg_pkg::CMD_SR_ENTER;
          nxt_pstate = P_SELFREF;
        end
        P_SELFREF: begin
          if (!self_ref_req) begin
            nxt_cmd = sdram_cfg_pkg::CMD_SR_EXIT;
            nxt_pstate = P_ACTIVE;
          end
        end
        P_STOP: begin
          if (!clock_stop_req) begin
            nxt_pstate = P_ACTIVE;
          end
        end
        default: nxt_pstate = P_ACTIVE;
      endcase
    end
  end

  logic [2:0] mem_cmd_ff;
  logic mem_cke_ff, mem_ready_ff, cmd_hold_ff;
  // cke low while stopped or self-refreshing
  wire nxt_cke = seq_cke && (nxt_pstate == P_ACTIVE || nxt_pstate == P_SR_ENTER);

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pstate_ff <= P_ACTIVE;
      mem_cmd_ff <= sdram_cfg_pkg::CMD_NOP;
      mem_cke_ff <= 1'b0;
      mem_ready_ff <= 1'b0;
      cmd_hold_ff <= 1'b1;
      refi_cnt_ff <= 32'h0000_0000;
      ref_pend_ff <= 1'b0;
      mode_pend_ff <= 1'b0;
      mrs_next_ff <= 1'b0;
    end else begin
      pstate_ff <= nxt_pstate;
      mem_cmd_ff <= nxt_cmd;
      mem_cke_ff <= nxt_cke;
      // memory usable only after the sequence
      mem_ready_ff <= seq_done;
      cmd_hold_ff <= !seq_done || (nxt_pstate != P_ACTIVE);
      refi_cnt_ff <= refi_tick || !periodic_on ? 32'h0000_0000 : refi_cnt_ff + 32'h0000_0001;
      // a new request beats the clear
      ref_pend_ff <= manual_ref_pulse || refi_tick || (ref_pend_ff && !ref_taken);
      mode_pend_ff <= mode_push_pulse || (mode_pend_ff && !mode_taken);
      mrs_next_ff <= mode_taken;
    end
  end

  assign cfg_rdata = cfg_rdata_ff;
  assign cfg_rd_valid = cfg_rd_valid_ff;
  assign mem_cmd = mem_cmd_ff;
  assign mem_cke = mem_cke_ff;
  assign mem_ready = mem_ready_ff;
  assign cmd_hold = cmd_hold_ff;

endmodule

// *** design/sdram_cfg_pkg.sv ***
package sdram_cfg_pkg;

  // ------------------------------------------------------------
  // address map
  // ------------------------------------------------------------
  localparam logic [63:0] CFG_BASE = 64'h0000_0000_0ff0_0000;
  localparam int NUM_REGS = 6;
  localparam logic [7:0] OFS_PAGE_REFRESH = 8'h00;
  localparam logic [7:0] OFS_WRITE_DLL = 8'h10;
  localparam logic [7:0] OFS_QUEUE_POWER = 8'h20;
  localparam logic [7:0] OFS_INIT_SWAP = 8'h30;
  localparam logic [7:0] OFS_ECC_TERM = 8'h40;
  localparam logic [7:0] OFS_QUEUE_DEPTH = 8'h50;
  localparam logic [63:0] RST_VALUE = 64'h0000_0000_0000_0000;

  // ------------------------------------------------------------
  // storable bits per register (write-only and reserved bits clear, except the launch bit, which is stored)
  // ------------------------------------------------------------
  localparam logic [63:0] WMASK_0 = 64'h0001_0101_0001_0100;
  localparam logic [63:0] WMASK_1 = 64'h0001_0101_0101_0000;
  localparam logic [63:0] WMASK_2 = 64'h0101_0101_0101_0101;
  localparam logic [63:0] WMASK_3 = 64'h0101_0101_0101_0101;
  localparam logic [63:0] WMASK_4 = 64'h0303_0303_0001_0101;
  localparam logic [63:0] WMASK_5 = 64'h0700_0000_0000_0000;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int B_OVERLAP = 48;
  localparam int B_BANK_SPLIT = 40;
  localparam int B_REF_BOUNDARY = 32;
  localparam int B_MANUAL_REF = 24;
  localparam int B_CLOSE_PAGE = 16;
  localparam int B_CONFLICT = 8;
  localparam int B_EARLY_WRITE = 48;
  localparam int B_BANK_COUNT = 32;
  localparam int B_DLL_LOCK = 0;
  localparam int B_PRIORITY = 56;
  localparam int B_CLOCK_STOP = 48;
  localparam int B_REORDER = 40;
  localparam int B_CS_TURN = 32;
  localparam int B_DLL_GUARD = 24;
  localparam int B_WR_PRE_WR = 16;
  localparam int B_RD_PRE_RD = 8;
  localparam int B_PRE_AP = 0;
  localparam int B_SWAP_PORT = 56;
  localparam int B_EXCHANGE = 48;
  localparam int B_LAUNCH = 40;
  localparam int B_SELF_REF = 32;
  localparam int B_RW_SAME = 24;
  localparam int B_HALF_WIDTH = 8;
  localparam int B_PWRUP_SR = 0;
  localparam int B_TERM_LO = 56;
  localparam int B_ECC_LO = 48;
  localparam int B_MODE_PUSH = 24;
  localparam int B_RD_BRK_WR = 16;
  localparam int B_PERIODIC = 8;

  // ------------------------------------------------------------
  // encodings
  // ------------------------------------------------------------
  localparam logic [1:0] TERM_OFF = 2'h0;
  localparam logic [1:0] ECC_REPORT = 2'h1;
  localparam logic [1:0] ECC_ABSENT = 2'h2;
  localparam logic [1:0] ECC_CORRECT = 2'h3;
  localparam logic [2:0] CMD_NOP = 3'h0;
  localparam logic [2:0] CMD_PRE_ALL = 3'h1;
  localparam logic [2:0] CMD_REFRESH = 3'h2;
  localparam logic [2:0] CMD_MRS = 3'h3;
  localparam logic [2:0] CMD_EMRS = 3'h4;
  localparam logic [2:0] CMD_SR_ENTER = 3'h5;
  localparam logic [2:0] CMD_SR_EXIT = 3'h6;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_REFI_NS = 7800;
  localparam int REFI_CYC = T_REFI_NS / CLK_PERIOD_NS;
  localparam int T_PWRUP_NS = 200000;
  localparam int PWRUP_CYC = (T_PWRUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DLL_CYC = 200;
  localparam int INIT_REF_CNT = 2;

endpackage

// *** design/sdram_init_seq.sv ***
`timescale 1ns/1ps
module sdram_init_seq #(
  parameter int WAIT_CYC = sdram_cfg_pkg::PWRUP_CYC,
  parameter int DLL_WAIT = sdram_cfg_pkg::DLL_CYC,
  parameter int REF_CNT = sdram_cfg_pkg::INIT_REF_CNT
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic start,
  input wire logic via_sr_exit,
  output logic [2:0] seq_cmd,
  output logic cke_on,
  output logic busy,
  output logic dll_window,
  output logic done
);

  typedef enum logic [8:0] {
    S_IDLE = 9'h001,
    S_WAIT = 9'h002,
    S_PRE = 9'h004,
    S_EMRS = 9'h008,
    S_MRS = 9'h010,
    S_DLL = 9'h020,
    S_REF = 9'h040,
    S_SREXIT = 9'h080,
    S_DONE = 9'h100
  } seq_state_t;

  seq_state_t state_ff, nxt_state;
  logic [31:0] cnt_ff;
  logic [31:0] nxt_cnt;
  wire cnt_end = (cnt_ff == 32'h0000_0000);

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff - 32'h0000_0001;
    case (state_ff)
      S_IDLE, S_DONE: begin
        nxt_cnt = 32'(WAIT_CYC - 1);
        if (start) begin
          nxt_state = S_WAIT;
        end
      end
      S_WAIT: begin
        if (cnt_end) begin
          nxt_state = via_sr_exit ? S_SREXIT : S_PRE;
        end
      end
      S_PRE: nxt_state = S_EMRS;
      S_EMRS: nxt_state = S_MRS;
      S_MRS: begin
        nxt_state = S_DLL;
        nxt_cnt = 32'(DLL_WAIT - 1);
      end
      S_DLL: begin
        if (cnt_end) begin
          nxt_state = S_REF;
          nxt_cnt = 32'(REF_CNT - 1);
        end
      end
      S_REF: begin
        if (cnt_end) begin
          nxt_state = S_DONE;
        end
      end
      S_SREXIT: nxt_state = S_DONE;
      default: nxt_state = S_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_ff <= S_IDLE;
      cnt_ff <= 32'h0000_0000;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
    end
  end

  assign seq_cmd = (state_ff == S_PRE) ? sdram_cfg_pkg::CMD_PRE_ALL :
                   (state_ff == S_EMRS) ? sdram_cfg_pkg::CMD_EMRS :
                   (state_ff == S_MRS) ? sdram_cfg_pkg::CMD_MRS :
                   (state_ff == S_REF) ? sdram_cfg_pkg::CMD_REFRESH :
                   (state_ff == S_SREXIT) ? sdram_cfg_pkg::CMD_SR_EXIT : sdram_cfg_pkg::CMD_NOP;
  assign cke_on = !(state_ff inside {S_IDLE, S_WAIT});
  assign busy = !(state_ff inside {S_IDLE, S_DONE});
  assign dll_window = (state_ff == S_DLL);
  assign done = (state_ff == S_DONE);

endmodule

// *** testbench/sdram_cfg_checker.sv ***
`timescale 1ns/1ps
module sdram_cfg_checker #(
  parameter logic [63:0] BASE_ADDR = 64'h0
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [63:0] cfg_addr,
  input wire logic [63:0] cfg_wdata,
  input wire logic [63:0] cfg_rdata,
  input wire logic cfg_rd_valid,
  input wire logic burst_boundary,
  input wire logic cmd_boundary,
  input wire logic [2:0] mem_cmd,
  input wire logic mem_ready,
  input wire logic cmd_hold,
  input wire logic reorder_enable,
  input wire logic reorder_priority,
  input wire logic preempt_exchange,
  input wire logic swap_same_port,
  input wire logic close_page_policy,
  input wire logic odt_enable,
  input wire logic [1:0] termination_select,
  input wire logic ecc_check_en,
  input wire logic ecc_correct_en,
  input wire logic ecc_dev_absent
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  property p_rd_lat; cfg_rd |=> cfg_rd_valid; endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
  property p_rd_idle; !cfg_rd_valid |-> cfg_rdata == 64'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
  property p_gate; reorder_priority |-> reorder_enable; endproperty
  a_gate: assert property (p_gate) else $error("priority without reorder");
  property p_swap; swap_same_port |-> preempt_exchange && reorder_enable; endproperty
  a_swap: assert property (p_swap) else $error("port swap ungated");
  property p_odt; odt_enable == (termination_select != 2'h0); endproperty
  a_odt: assert property (p_odt) else $error("termination enable wrong");
  property p_ecc; ecc_correct_en |-> ecc_check_en && !ecc_dev_absent; endproperty
  a_ecc: assert property (p_ecc) else $error("ecc mode mix");
  property p_hold; !mem_ready |-> cmd_hold; endproperty
  a_hold: assert property (p_hold) else $error("commands let through early");
  property p_push; mem_cmd == sdram_cfg_pkg::CMD_EMRS |=> mem_cmd == sdram_cfg_pkg::CMD_MRS; endproperty
  a_push: assert property (p_push) else $error("mode pair broken");
  property p_page;
    cfg_wr && cfg_addr == BASE_ADDR |-> ##2 close_page_policy == $past(cfg_wdata[16], 2);
  endproperty
  a_page: assert property (p_page) else $error("page policy not taken");
  property p_ref;
    mem_cmd == sdram_cfg_pkg::CMD_REFRESH && $past(mem_ready) |-> $past(burst_boundary || cmd_boundary);
  endproperty
  a_ref: assert property (p_ref) else $error("refresh off boundary");
endmodule
bind sdram_ctrl_config_and_init sdram_cfg_checker #(.BASE_ADDR(BASE_ADDR)) sdram_cfg_checker_i (
  .mclk, .sys_rst, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_wdata, .cfg_rdata, .cfg_rd_valid, .burst_boundary,
  .cmd_boundary, .mem_cmd, .mem_ready, .cmd_hold, .reorder_enable, .reorder_priority, .preempt_exchange,
  .swap_same_port, .close_page_policy, .odt_enable, .termination_select, .ecc_check_en, .ecc_correct_en,
  .ecc_dev_absent);

// *** testbench/sdram_mem_model.sv ***
`timescale 1ns/1ps
module sdram_mem_model (
  input wire logic mclk,
  input wire logic mem_cke,
  output logic dll_lock_in,
  output logic burst_boundary,
  output logic cmd_boundary
);
  int lk = 0;
  int ph = 0;
  initial begin
    dll_lock_in = 0;
    burst_boundary = 0;
    cmd_boundary = 0;
  end
  always @(negedge mclk) begin
    lk = mem_cke ? ((lk < 8) ? lk + 1 : lk) : 0;
    ph = (ph + 1) % 6;
    dll_lock_in = (lk == 8);
    burst_boundary = (ph % 3 == 0);
    cmd_boundary = (ph == 5);
  end
endmodule

// *** testbench/test_sdram_ctrl_config_and_init.sv ***
`timescale 1ns/1ps
module test_sdram_ctrl_config_and_init;
  localparam logic [63:0] B = sdram_cfg_pkg::CFG_BASE;
  logic mclk = 0, sys_rst = 1, cfg_wr = 0, cfg_rd = 0;
  logic [63:0] cfg_addr = B, cfg_wdata = 0, cfg_rdata;
  logic cfg_rd_valid, dll_lock_in, burst_boundary, cmd_boundary, mem_cke, mem_ready, cmd_hold;
  logic [2:0] mem_cmd;
  logic close_page_policy, reorder_priority, swap_same_port, odt_enable, half_width_data;
  logic ecc_check_en, ecc_correct_en, ecc_dev_absent;
  logic [1:0] termination_select;
  logic [23:0] seq;
  wire [12:0] pol;
  int n_mismatch = 0, checks = 0, cnt;
  logic [63:0] m[6] = '{sdram_cfg_pkg::WMASK_0, sdram_cfg_pkg::WMASK_1, sdram_cfg_pkg::WMASK_2,
    sdram_cfg_pkg::WMASK_3, sdram_cfg_pkg::WMASK_4, sdram_cfg_pkg::WMASK_5};
  logic [63:0] x[6] = '{64'h100_0000, 64'h0, 64'h1_0000_0000_0000, 64'h101_0000_0001, 64'h100_0100, 64'h0};
  sdram_ctrl_config_and_init #(.PWRUP_WAIT(20), .REFI(50), .DLL_WAIT(10), .INIT_REFS(2))
    sdram_ctrl_config_and_init_i (.mclk, .sys_rst, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_wdata, .cfg_rdata,
    .cfg_rd_valid, .dll_lock_in, .burst_boundary, .cmd_boundary, .mem_cmd, .mem_cke, .mem_ready, .cmd_hold,
    .overlap_precharge_cmd(pol[12]), .reorder_enable(pol[11]), .reorder_priority, .reorder_bank_split(pol[10]),
    .conflict_check_enable(pol[9]), .reorder_rw_same(pol[8]), .preempt_exchange(pol[7]), .swap_same_port,
    .close_page_policy, .early_write_issue(pol[6]), .bank_count_select(pol[5]), .cs_turnaround_enable(pol[4]),
    .write_preempt_write(pol[3]), .read_preempt_read(pol[2]), .preempt_autoprecharge(pol[1]),
    .read_breaks_write_burst(pol[0]), .odt_enable,
    .termination_select, .ecc_check_en, .ecc_correct_en, .ecc_dev_absent, .half_width_data);
  sdram_mem_model sdram_mem_model_i (.mclk, .mem_cke, .dll_lock_in, .burst_boundary, .cmd_boundary);
  initial begin
    forever #5 mclk = ~mclk;
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wr(input logic [7:0] o, input logic [63:0] d);
    @(negedge mclk);
    {cfg_wr, cfg_addr, cfg_wdata} = {1'b1, B + o, d};
    @(negedge mclk);
    cfg_wr = 0;
  endtask
  task rd(input logic [7:0] o, input logic [63:0] e);
    @(negedge mclk);
    {cfg_rd, cfg_addr} = {1'b1, B + o};
    @(negedge mclk);
    cfg_rd = 0;
    chk("rd_valid", cfg_rd_valid, 1);
    chk("rdata", cfg_rdata, e);
  endtask
  // non-idle commands shifted in, three bits each
  task run(input int n);
    seq = 0;
    cnt = 0;
    repeat (n) begin
      @(negedge mclk);
      if (mem_cmd !== sdram_cfg_pkg::CMD_NOP) begin
        seq = {seq[20:0], mem_cmd};
        cnt++;
      end
    end
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_regs;
    for (int i = 0; i < 6; i++) rd(i * 16, 0);
    chk("pre", {mem_ready, mem_cke, cmd_hold}, 3'b001);
    for (int i = 0; i < 6; i++) wr(i * 16, ~x[i]);
    for (int i = 0; i < 6; i++) rd(i * 16, ~x[i] & m[i]);
    chk("pol", {close_page_policy, reorder_priority, swap_same_port, half_width_data}, 4'hf);
    chk("pol_on", pol, 13'h1fff);
    wr(8'h60, '1);
    rd(8'h60, 0);
    rd(8'h08, 0);
    wr(8'h20, ~64'h1_0100_0000_0000);
    // policy outputs trail the register by one more clock
    @(negedge mclk);
    chk("gate", {reorder_priority, swap_same_port}, 2'b00);
    chk("pol_gate", pol, 13'h107f);
    for (int i = 0; i < 4; i++) begin
      wr(8'h40, (64'(i) << 56) | (64'(i) << 48));
      @(negedge mclk);
      chk("ecc", {ecc_check_en, ecc_correct_en, ecc_dev_absent}, {i[0], i == 3, i == 2});
      chk("odt", {odt_enable, termination_select}, {i != 0, 2'(i)});
    end
    for (int i = 0; i < 6; i++) wr(i * 16, 0);
    @(negedge mclk);
    chk("overlap", pol[12], 0);
    chk("early", pol[6], 0);
    chk("banks", pol[5], 0);
    chk("turn", pol[4], 0);
    $display("done t_regs");
  endtask
  task t_init;
    wr(8'h20, 64'h100_0000);
    // a mode push left pending must wait out the guarded settling time
    wr(8'h40, 64'h100_0000);
    wr(8'h30, 64'h100_0000_0000);
    run(80);
    chk("init", seq, {3'h0, 3'h1, 3'h4, 3'h3, 3'h2, 3'h2, 3'h4, 3'h3});
    chk("rdy", {mem_ready, mem_cke, cmd_hold}, 3'b110);
    rd(8'h10, 64'h1);
    $display("done t_init");
  endtask
  task t_cmds;
    wr(8'h40, 64'h100_0000);
    run(10);
    chk("push", seq, {18'h0, 3'h4, 3'h3});
    rd(8'h40, 0);
    for (int s = 1; s >= 0; s--) begin
      wr(8'h00, (64'(s) << 32) | 64'h100_0000);
      run(20);
      chk("mref", seq, 24'h2);
      rd(8'h00, 64'(s) << 32);
    end
    wr(8'h40, 64'h100);
    run(150);
    chk("per", cnt >= 2 && cnt <= 3, 1);
    wr(8'h40, 0);
    run(10);
    run(120);
    chk("peroff", cnt, 0);
    $display("done t_cmds");
  endtask
  task t_power;
    wr(8'h20, 64'h1_0000_0000_0000);
    run(10);
    chk("stop", {seq, mem_cke, cmd_hold}, {24'h1, 2'b01});
    wr(8'h20, 0);
    run(5);
    chk("go", {mem_cke, cmd_hold}, 2'b10);
    wr(8'h30, 64'h1_0000_0000);
    run(10);
    chk("sr", {seq, mem_cke}, {18'h0, 3'h1, 3'h5, 1'b0});
    wr(8'h30, 0);
    run(10);
    chk("srx", {seq, mem_cke}, {21'h0, 3'h6, 1'b1});
    wr(8'h30, 64'h100_0000_0001);
    run(40);
    chk("srup", {seq, mem_ready, mem_cke}, {24'h6, 2'b11});
    $display("done t_power");
  endtask
  initial begin
    repeat (16) @(negedge mclk);
    sys_rst = 0;
    t_regs();
    t_init();
    t_cmds();
    t_power();
    end_of_test();
  end
  initial begin
    repeat (6000) @(posedge mclk);
    n_mismatch++;
    end_of_test();
  end
endmodule
